// ---- adcrt_clkdiv.sv ----
/*
 * Converter clock divider: divides the system clock by a fixed ratio.
 * Assumes clr_i holds the divider at phase zero outside conversions.
 */
`timescale 1ns/1ps
`default_nettype none
module adcrt_clkdiv
    import adcrt_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    input  wire logic clr_i,
    output logic      tick_o,
    output logic      clk_o
);
    logic [3:0] div_q;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_q <= 4'h0;
        end else if (ce_i) begin
            div_q <= clr_i ? 4'h0 : div_q + 4'h1;
        end
    end

    // Tick marks the last system cycle of each converter clock period
    assign tick_o = ce_i && !clr_i && (div_q == 4'(CONV_DIV - 1));
    assign clk_o  = div_q[3];
endmodule
`default_nettype wire

// ---- adcrt_core_model.sv ----
/*
 * Behavioural analog core: presents the value to convert while hold is high.
 * Assumes the bench supplies the value and the block samples it late in hold.
 */
`timescale 1ns/1ps
`default_nettype none
module adcrt_core_model (
    input  wire logic       clk_i,
    input  wire logic       hold_i,
    input  wire logic [9:0] val_i,
    output logic      [9:0] res_o
);
    // Churns outside hold so a result taken at the wrong time is caught
    initial res_o = 10'h155;
    always @(posedge clk_i) begin
        if (hold_i) begin
            res_o <= val_i;
        end else begin
            res_o <= ~res_o;
        end
    end
endmodule
`default_nettype wire

// ---- adcrt_pkg.sv ----
/*
 * Shared constants and types of the converter result and sample timing block.
 * Assumes a 100 MHz system clock and an AXI4-Lite register bus with 32-bit data.
 */
`default_nettype none
package adcrt_pkg;
    localparam int          ADDR_W         = 16;
    localparam int          DATA_W         = 32;
    // Register indices; byte address is index times four
    localparam logic [11:0] IDX_CTRL       = 12'hf70;
    localparam logic [11:0] IDX_RES_HI     = 12'hf72;
    localparam logic [11:0] IDX_RES_LO     = 12'hf73;
    localparam logic [11:0] IDX_SETTLE     = 12'hf74;
    localparam logic [11:0] IDX_SAMPLE     = 12'hf75;
    localparam logic [11:0] IDX_IRQ_STAT   = 12'hf76;
    localparam logic [11:0] IDX_IRQ_MASK   = 12'hf77;
    localparam int          CTRL_START_BIT = 7;
    localparam int          CTRL_EN_BIT    = 4;
    localparam int          IRQ_DONE_BIT   = 0;
    localparam int          RES_W          = 10;
    localparam int          SETTLE_W       = 4;
    localparam int          SAMPLE_W       = 6;
    localparam logic [3:0]  SETTLE_RST     = 4'hf;
    localparam logic [5:0]  SAMPLE_RST     = 6'h3f;
    localparam int          CONV_DIV       = 16;
    localparam int          CONV_CYCLES    = 13;
    localparam int          CONV_LEN_CYC   = CONV_CYCLES * CONV_DIV;
    // Guidance for software only: minimum phase lengths at this clock
    localparam int          CLK_PERIOD_NS  = 10;
    localparam int          MIN_SAMPLE_NS  = 1000;
    localparam int          MIN_SETTLE_NS  = 500;
    localparam int          MIN_SAMPLE_CYC = (MIN_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          MIN_SETTLE_CYC = (MIN_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0]  RESP_OKAY      = 2'b00;
    localparam logic [1:0]  RESP_SLVERR    = 2'b10;

    typedef enum logic [1:0] {S_IDLE, S_SAMPLE, S_SETTLE, S_CONV} adcrt_state_t;
endpackage
`default_nettype wire

// ---- adcrt_sync.sv ----
/*
 * Two-stage synchroniser for a bus of asynchronous inputs.
 * Assumes the bus is quasi-static when sampled by the reader.
 */
`timescale 1ns/1ps
`default_nettype none
module adcrt_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= '0;
            q_o    <= '0;
        end else if (ce_i) begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ---- adcrt_top.sv ----
/*
 * Converter control: AXI4-Lite registers, sample/settle/convert sequencing,
 * result capture and the completion interrupt.
 * Assumes the analog core presents its 10-bit result on CORE_RESULT_I,
 * stable by the end of the conversion phase.
 */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - High byte read-only; writes ignored
// - High byte read latches low bits
// - Low bits in [7:6], rest zero
// - Result registers undefined after reset
// - Result held until next conversion completes
// - Settle phase lasts settle field cycles, one cycle if the field is zero
// - Sample phase lasts sample field cycles, one cycle if the field is zero
// - Start bit launches; reads busy status
// - New start aborts and restarts sequence
// - Conversion lasts 13 clocks of div16
// - Completion raises interrupt; disable keeps it
module adcrt_top
    import adcrt_pkg::*;
(
    input  wire logic              CORE_CLK_I,
    input  wire logic              RST_I,
    input  wire logic              CE_I,
    input  wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
    input  wire logic              S_AXI_AWVALID_I,
    output logic                   S_AXI_AWREADY_O,
    input  wire logic [DATA_W-1:0] S_AXI_WDATA_I,
    input  wire logic [3:0]        S_AXI_WSTRB_I,
    input  wire logic              S_AXI_WVALID_I,
    output logic                   S_AXI_WREADY_O,
    output logic [1:0]             S_AXI_BRESP_O,
    output logic                   S_AXI_BVALID_O,
    input  wire logic              S_AXI_BREADY_I,
    input  wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
    input  wire logic              S_AXI_ARVALID_I,
    output logic                   S_AXI_ARREADY_O,
    output logic [DATA_W-1:0]      S_AXI_RDATA_O,
    output logic [1:0]             S_AXI_RRESP_O,
    output logic                   S_AXI_RVALID_O,
    input  wire logic              S_AXI_RREADY_I,
    input  wire logic [RES_W-1:0]  CORE_RESULT_I,
    output logic                   SAMPLE_O,
    output logic                   HOLD_O,
    output logic                   CONV_START_O,
    output logic                   CONV_CLK_O,
    output logic                   IRQ_O
);
    function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [11:0] idx);
        return a == {idx, 2'b00};
    endfunction

    // A zero count still gives a one-cycle phase
    function automatic logic [5:0] eff_len(input logic [5:0] n);
        return (n == 6'h00) ? 6'h01 : n;
    endfunction

    adcrt_state_t      state_q;
    adcrt_state_t      state_d;
    logic [5:0]        cnt_q;
    logic [5:0]        cnt_d;
    logic [3:0]        tcnt_q;
    logic [3:0]        settle_q;
    logic [5:0]        sample_q;
    logic [3:0]        settle_run_q;
    logic [5:0]        sample_run_q;
    logic              en_q;
    logic              stat_q;
    logic              mask_q;
    logic [7:0]        res_hi_q;
    logic [1:0]        res_lsb_q;
    logic [1:0]        lsb_out_q;
    logic              conv_start_q;
    logic [RES_W-1:0]  core_res;
    logic              tick;
    logic              done;
    logic              busy;

    logic              aw_full_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic              w_full_q;
    logic [7:0]        w_data_q;
    logic              w_lane0_q;
    logic              do_wr;
    logic              wr_ok;
    logic              wr_ctrl;
    logic              wr_hit;
    logic              start_req;
    logic              abort_req;
    logic              ar_hs;
    logic              rd_ok;
    logic [7:0]        rd_byte;

    adcrt_sync #(
        .W(RES_W)
    ) u_sync (
        .clk_i (CORE_CLK_I),
        .rst_i (RST_I),
        .ce_i  (CE_I),
        .d_i   (CORE_RESULT_I),
        .q_o   (core_res)
    );

    adcrt_clkdiv u_div (
        .clk_i  (CORE_CLK_I),
        .rst_i  (RST_I),
        .ce_i   (CE_I),
        .clr_i  (state_q != S_CONV),
        .tick_o (tick),
        .clk_o  (CONV_CLK_O)
    );

    // Write channel: address and data are taken independently, in either order
    assign S_AXI_AWREADY_O = CE_I && !aw_full_q;
    assign S_AXI_WREADY_O  = CE_I && !w_full_q;
    assign do_wr           = CE_I && aw_full_q && w_full_q && !S_AXI_BVALID_O;
    assign wr_ok           = do_wr && w_lane0_q;
    assign wr_ctrl         = wr_ok && reg_hit(aw_addr_q, IDX_CTRL);
    assign start_req       = wr_ctrl && w_data_q[CTRL_START_BIT] && w_data_q[CTRL_EN_BIT];
    assign abort_req       = wr_ctrl && !w_data_q[CTRL_EN_BIT];

    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            aw_full_q <= 1'b0;
            aw_addr_q <= '0;
        end else if (CE_I) begin
            if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
                aw_full_q <= 1'b1;
                aw_addr_q <= S_AXI_AWADDR_I;
            end else if (do_wr) begin
                aw_full_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            w_full_q  <= 1'b0;
            w_data_q  <= 8'h00;
            w_lane0_q <= 1'b0;
        end else if (CE_I) begin
            if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
                w_full_q  <= 1'b1;
                w_data_q  <= S_AXI_WDATA_I[7:0];
                w_lane0_q <= S_AXI_WSTRB_I[0];
            end else if (do_wr) begin
                w_full_q <= 1'b0;
            end
        end
    end

    always_comb begin
        case (1'b1)
            reg_hit(aw_addr_q, IDX_CTRL),
            reg_hit(aw_addr_q, IDX_RES_HI),
            reg_hit(aw_addr_q, IDX_RES_LO),
            reg_hit(aw_addr_q, IDX_SETTLE),
            reg_hit(aw_addr_q, IDX_SAMPLE),
            reg_hit(aw_addr_q, IDX_IRQ_STAT),
            reg_hit(aw_addr_q, IDX_IRQ_MASK): wr_hit = 1'b1;
            default:                          wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            S_AXI_BVALID_O <= 1'b0;
            S_AXI_BRESP_O  <= RESP_OKAY;
        end else if (CE_I) begin
            if (do_wr) begin
                S_AXI_BVALID_O <= 1'b1;
                S_AXI_BRESP_O  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (S_AXI_BREADY_I) begin
                S_AXI_BVALID_O <= 1'b0;
            end
        end
    end

    // Writable configuration; result registers have no write path at all
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            settle_q <= SETTLE_RST;
            sample_q <= SAMPLE_RST;
            en_q     <= 1'b0;
            mask_q   <= 1'b0;
        end else if (wr_ok) begin
            if (reg_hit(aw_addr_q, IDX_SETTLE)) begin
                settle_q <= w_data_q[SETTLE_W-1:0];
            end
            if (reg_hit(aw_addr_q, IDX_SAMPLE)) begin
                sample_q <= w_data_q[SAMPLE_W-1:0];
            end
            if (wr_ctrl) begin
                en_q <= w_data_q[CTRL_EN_BIT];
            end
            if (reg_hit(aw_addr_q, IDX_IRQ_MASK)) begin
                mask_q <= w_data_q[IRQ_DONE_BIT];
            end
        end
    end

    // Sequencer: sample, then settle, then thirteen converter clocks
    assign done = (state_q == S_CONV) && tick && (tcnt_q == 4'(CONV_CYCLES - 1));
    assign busy = (state_q != S_IDLE);

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            S_IDLE: begin
                state_d = S_IDLE;
            end
            S_SAMPLE: begin
                cnt_d = cnt_q - 6'h01;
                if (cnt_q == 6'h00) begin
                    state_d = S_SETTLE;
                    cnt_d   = eff_len({2'b00, settle_run_q}) - 6'h01;
                end
            end
            S_SETTLE: begin
                cnt_d = cnt_q - 6'h01;
                if (cnt_q == 6'h00) begin
                    state_d = S_CONV;
                    cnt_d   = 6'h00;
                end
            end
            S_CONV: begin
                if (done) begin
                    state_d = S_IDLE;
                end
            end
            default: begin
                state_d = S_IDLE;
                cnt_d   = 6'h00;
            end
        endcase
        if (start_req) begin
            state_d = S_SAMPLE;
            cnt_d   = eff_len(sample_q) - 6'h01;
        end else if (abort_req) begin
            state_d = S_IDLE;
            cnt_d   = 6'h00;
        end
    end

    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state_q      <= S_IDLE;
            cnt_q        <= 6'h00;
            settle_run_q <= SETTLE_RST;
            sample_run_q <= SAMPLE_RST;
            conv_start_q <= 1'b0;
        end else if (CE_I) begin
            state_q      <= state_d;
            cnt_q        <= cnt_d;
            conv_start_q <= (state_q == S_SETTLE) && (state_d == S_CONV);
            // Counts are frozen per run so a mid-run write cannot warp a phase
            if (start_req) begin
                settle_run_q <= settle_q;
                sample_run_q <= sample_q;
            end
        end
    end

    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            tcnt_q <= 4'h0;
        end else if (CE_I) begin
            if (state_q != S_CONV) begin
                tcnt_q <= 4'h0;
            end else if (tick) begin
                tcnt_q <= tcnt_q + 4'h1;
            end
        end
    end

    assign SAMPLE_O     = (state_q == S_SAMPLE);
    assign HOLD_O       = (state_q == S_SETTLE) || (state_q == S_CONV);
    assign CONV_START_O = conv_start_q;

    // Result storage has no reset; contents are meaningless until a conversion
    always_ff @(posedge CORE_CLK_I) begin
        if (CE_I && done) begin
            res_hi_q  <= core_res[RES_W-1:2];
            res_lsb_q <= core_res[1:0];
        end
        if (ar_hs && reg_hit(S_AXI_ARADDR_I, IDX_RES_HI)) begin
            lsb_out_q <= res_lsb_q;
        end
    end

    // Completion is sticky; a disable does not clear it, and set beats clear
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            stat_q <= 1'b0;
        end else if (CE_I) begin
            stat_q <= done || (stat_q && !(wr_ok && reg_hit(aw_addr_q, IDX_IRQ_STAT)
                      && w_data_q[IRQ_DONE_BIT]));
        end
    end

    assign IRQ_O = stat_q && mask_q;

    // Read channel
    assign S_AXI_ARREADY_O = CE_I && !S_AXI_RVALID_O;
    assign ar_hs           = S_AXI_ARVALID_I && S_AXI_ARREADY_O;

    always_comb begin
        rd_ok   = 1'b1;
        rd_byte = 8'h00;
        case (1'b1)
            reg_hit(S_AXI_ARADDR_I, IDX_CTRL):     rd_byte = {busy, 2'b00, en_q, 4'h0};
            reg_hit(S_AXI_ARADDR_I, IDX_RES_HI):   rd_byte = res_hi_q;
            reg_hit(S_AXI_ARADDR_I, IDX_RES_LO):   rd_byte = {lsb_out_q, 6'h00};
            reg_hit(S_AXI_ARADDR_I, IDX_SETTLE):   rd_byte = {4'h0, settle_q};
            reg_hit(S_AXI_ARADDR_I, IDX_SAMPLE):   rd_byte = {2'b00, sample_q};
            reg_hit(S_AXI_ARADDR_I, IDX_IRQ_STAT): rd_byte = {7'h00, stat_q};
            reg_hit(S_AXI_ARADDR_I, IDX_IRQ_MASK): rd_byte = {7'h00, mask_q};
            default:                               rd_ok   = 1'b0;
        endcase
    end

    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            S_AXI_RVALID_O <= 1'b0;
            S_AXI_RDATA_O  <= '0;
            S_AXI_RRESP_O  <= RESP_OKAY;
        end else if (CE_I) begin
            if (ar_hs) begin
                S_AXI_RVALID_O <= 1'b1;
                S_AXI_RDATA_O  <= {24'h000000, rd_byte};
                S_AXI_RRESP_O  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (S_AXI_RREADY_I) begin
                S_AXI_RVALID_O <= 1'b0;
            end
        end
    end

    // Checking helpers: phase age, result validity, low-register read marker
    logic [7:0] age_q;
    logic       have_res_q;
    logic       rd_lo_q;

    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            age_q      <= 8'h01;
            have_res_q <= 1'b0;
            rd_lo_q    <= 1'b0;
        end else if (CE_I) begin
            age_q      <= (state_d != state_q || start_req) ? 8'h01 : age_q + 8'h01;
            have_res_q <= have_res_q || done;
            if (ar_hs) begin
                rd_lo_q <= reg_hit(S_AXI_ARADDR_I, IDX_RES_LO);
            end
        end
    end

    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (RST_I || !CE_I);

    sequence s_hi_read;
        ar_hs && reg_hit(S_AXI_ARADDR_I, IDX_RES_HI) && have_res_q;
    endsequence
    sequence s_settle_end;
        state_q == S_SETTLE && state_d == S_CONV && !start_req && !abort_req;
    endsequence
    sequence s_sample_end;
        state_q == S_SAMPLE && state_d == S_SETTLE && !start_req && !abort_req;
    endsequence
    sequence s_done_quiet;
        done && !start_req && !abort_req;
    endsequence

    a_hi_read_only: assert property ((do_wr && reg_hit(aw_addr_q, IDX_RES_HI) && !done && have_res_q)
        |=> $stable(res_hi_q)) else $error("write changed high byte");
    a_lsb_latch: assert property (s_hi_read |=> lsb_out_q == $past(res_lsb_q))
        else $error("low bits not latched on high read");
    a_low_layout: assert property ((S_AXI_RVALID_O && rd_lo_q && have_res_q)
        |-> S_AXI_RDATA_O[7:0] == {lsb_out_q, 6'h00}) else $error("low bits layout wrong");
    a_result_hold: assert property ((have_res_q && !done) |=> $stable(res_hi_q) && $stable(res_lsb_q))
        else $error("result changed without completion");
    a_settle_len: assert property (s_settle_end |-> age_q == {2'b00, eff_len({2'b00, settle_run_q})}
        ##1 CONV_START_O) else $error("settle length wrong");
    a_sample_len: assert property (s_sample_end |-> age_q == {2'b00, eff_len(sample_run_q)})
        else $error("sample length wrong");
    a_start_busy: assert property ((start_req && !busy) |=> SAMPLE_O ##0 busy)
        else $error("start did not launch");
    a_restart_seq: assert property ((start_req && busy) |=> state_q == S_SAMPLE && age_q == 8'h01)
        else $error("restart did not reset sequence");
    a_conv_len: assert property (s_done_quiet |-> age_q == 8'(CONV_LEN_CYC))
        else $error("conversion length wrong");
    a_irq_on_done: assert property (done |=> stat_q) else $error("completion flag not set");
    a_busy_drop: assert property (s_done_quiet |=> !busy && res_hi_q == $past(core_res[RES_W-1:2]))
        else $error("busy and result not aligned");
endmodule
`default_nettype wire

// ---- tb.sv ----
/*
 * Self-checking bench for the converter result and sample timing block.
 * Assumes the package, the top module and the analog core model come first.
 */
`timescale 1ns/1ps
`default_nettype none
module tb
    import adcrt_pkg::*;
();
    logic        clk = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, tchk = 1'b0, psmp = 1'b0, phld = 1'b0, pcclk = 1'b0;
    logic [15:0] awaddr = 16'h0, araddr = 16'h0;
    logic [31:0] wdata = 32'h0, rdata, seed = 32'h42b5, r;
    logic [3:0]  wstrb = 4'hf;
    logic [1:0]  bresp, rresp;
    logic        awready, wready, bvalid, arready, rvalid, smp, hld, cst, cclk, irq;
    logic [9:0]  core_val = 10'h0, core_res;
    int          mismatches = 0, compares = 0, scnt = 0, hcnt = 0, ccnt = 0;
    logic [33:0] rq[$];
    logic [1:0]  bq[$];
    int          tq[$];

    adcrt_top dut (.CORE_CLK_I(clk), .RST_I(rst), .CE_I(1'b1),
        .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
        .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
        .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
        .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
        .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
        .CORE_RESULT_I(core_res), .SAMPLE_O(smp), .HOLD_O(hld), .CONV_START_O(cst),
        .CONV_CLK_O(cclk), .IRQ_O(irq));
    adcrt_core_model core (.clk_i(clk), .hold_i(hld), .val_i(core_val), .res_o(core_res));

    initial begin
        forever #5 clk = ~clk;
    end

    function automatic logic [15:0] ba(input logic [11:0] i);
        return {2'b00, i, 2'b00};
    endfunction

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Handshakes are judged at the negedge, where the readies have settled
    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ha, hw, hb;
        int   n;
        @(posedge clk);
        bq.push_back(er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        hb = 1'b0;
        n = 0;
        while (!hb && n < 1000) begin
            @(negedge clk);
            ha = awvalid & awready;
            hw = wvalid & wready;
            hb = bvalid & bready;
            @(posedge clk);
            if (ha) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
            n++;
        end
        bready <= 1'b0;
        if (!hb) mismatches++;
    endtask

    task automatic rd(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ha, hr;
        int   n;
        @(posedge clk);
        rq.push_back({er, ed});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        hr = 1'b0;
        n = 0;
        while (!hr && n < 1000) begin
            @(negedge clk);
            ha = arvalid & arready;
            hr = rvalid & rready;
            @(posedge clk);
            if (ha) arvalid <= 1'b0;
            n++;
        end
        rready <= 1'b0;
        if (!hr) mismatches++;
    endtask

    task automatic wait_hold(input logic lv);
        int n;
        n = 0;
        while (hld !== lv && n < 1000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 1000) mismatches++;
    endtask

    task automatic rdres(input logic [9:0] v);
        rd(ba(IDX_RES_HI), {24'h0, v[9:2]}, RESP_OKAY);
        rd(ba(IDX_RES_LO), {24'h0, v[1:0], 6'h0}, RESP_OKAY);
    endtask

    // With ab set the run is restarted in mid-hold and v2 is the value that must win
    task automatic conv(input logic [5:0] st, input logic [3:0] settle_count_field, input logic [9:0] v, input logic m,
                        input logic ab, input logic [9:0] v2);
        int s1, s2;
        s1 = (st == 0) ? 1 : int'(st);
        s2 = (settle_count_field == 0) ? 1 : int'(settle_count_field);
        core_val <= v;
        tchk <= !ab;
        wr(ba(IDX_SAMPLE), {26'h0, st}, RESP_OKAY);
        wr(ba(IDX_SETTLE), {28'h0, settle_count_field}, RESP_OKAY);
        wr(ba(IDX_IRQ_MASK), {31'h0, m}, RESP_OKAY);
        // Clear any older completion so the flag seen after this run is this run's own
        wr(ba(IDX_IRQ_STAT), 32'h1, RESP_OKAY);
        chk("irq_clear", {33'h0, irq}, 34'h0);
        if (!ab) begin
            tq.push_back(s1);
            tq.push_back(s2);
            tq.push_back(s2 + CONV_LEN_CYC);
        end
        wr(ba(IDX_CTRL), 32'h90, RESP_OKAY);
        rd(ba(IDX_CTRL), 32'h90, RESP_OKAY);
        wait_hold(1'b1);
        if (ab) begin
            repeat (40) @(posedge clk);
            core_val <= v2;
            wr(ba(IDX_CTRL), 32'h90, RESP_OKAY);
            wait_hold(1'b0);
            wait_hold(1'b1);
        end
        wait_hold(1'b0);
        chk("irq", {33'h0, irq}, {33'h0, m});
        rd(ba(IDX_CTRL), 32'h10, RESP_OKAY);
    endtask

    always @(posedge clk) begin
        if (rvalid && rready) chk("rdata", {rresp, rdata}, rq.pop_front());
        if (bvalid && bready) chk("bresp", {32'h0, bresp}, {32'h0, bq.pop_front()});
        scnt <= smp ? scnt + 1 : 0;
        hcnt <= hld ? hcnt + 1 : 0;
        ccnt <= !hld ? 0 : (cclk && !pcclk) ? ccnt + 1 : ccnt;
        psmp <= smp;
        phld <= hld;
        pcclk <= cclk;
        if (tchk && psmp && !smp) chk("sample_len", 34'(scnt), 34'(tq.pop_front()));
        if (tchk && cst) chk("settle_len", 34'(hcnt), 34'(tq.pop_front()));
        if (tchk && phld && !hld) begin
            chk("hold_len", 34'(hcnt), 34'(tq.pop_front()));
            chk("conv_clocks", 34'(ccnt), 34'(CONV_CYCLES));
        end
    end

    initial begin
        repeat (60000) @(posedge clk);
        mismatches++;
        final_report();
    end

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd(ba(IDX_SETTLE), 32'h0f, RESP_OKAY);
        rd(ba(IDX_SAMPLE), 32'h3f, RESP_OKAY);
        rd(ba(IDX_CTRL), 32'h0, RESP_OKAY);
        rd(ba(IDX_IRQ_STAT), 32'h0, RESP_OKAY);
        rd(ba(IDX_IRQ_MASK), 32'h0, RESP_OKAY);
        rd(16'h0100, 32'h0, RESP_SLVERR);
        wr(16'h0100, 32'h5, RESP_SLVERR);
        wstrb <= 4'h0;
        wr(ba(IDX_SETTLE), 32'h3, RESP_OKAY);
        wstrb <= 4'hf;
        rd(ba(IDX_SETTLE), 32'h0f, RESP_OKAY);
        $display("test reset_and_map done");
        wr(ba(IDX_CTRL), 32'h10, RESP_OKAY);
        rd(ba(IDX_CTRL), 32'h10, RESP_OKAY);
        for (int i = 0; i < 6; i++) begin
            r = xs();
            conv((i == 0) ? 6'h0 : (i == 1) ? 6'h3f : r[5:0], (i == 0) ? 4'h0 : (i == 1) ? 4'hf : r[9:6],
                 r[19:10], i[0], 1'b0, 10'h0);
            rdres(r[19:10]);
            rd(ba(IDX_IRQ_STAT), 32'h1, RESP_OKAY);
            wr(ba(IDX_IRQ_STAT), 32'h1, RESP_OKAY);
            rd(ba(IDX_IRQ_STAT), 32'h0, RESP_OKAY);
        end
        $display("test timing_and_result done");
        conv(6'h2, 4'h3, 10'h2c1, 1'b1, 1'b0, 10'h0);
        rd(ba(IDX_RES_HI), 32'hb0, RESP_OKAY);
        conv(6'h1, 4'h1, 10'h1fe, 1'b1, 1'b0, 10'h0);
        rd(ba(IDX_RES_LO), 32'h40, RESP_OKAY);
        rdres(10'h1fe);
        wr(ba(IDX_RES_HI), 32'hff, RESP_OKAY);
        rd(ba(IDX_RES_HI), 32'h7f, RESP_OKAY);
        $display("test latch_and_readonly done");
        conv(6'h14, 4'h2, 10'h0a5, 1'b1, 1'b1, 10'h35a);
        rdres(10'h35a);
        wr(ba(IDX_CTRL), 32'h0, RESP_OKAY);
        rd(ba(IDX_IRQ_STAT), 32'h1, RESP_OKAY);
        chk("irq", {33'h0, irq}, 34'h1);
        $display("test abort_and_disable done");
        final_report();
    end
endmodule
`default_nettype wire
